// *** tb/ibc_host_model.sv ***
// host model: one-cycle register writes and reads into the bank
`timescale 1ns/10ps
module ibc_host_model (
	input  wire logic       clk_i,   // core clock
	output logic      [7:0] addr_o,  // register offset
	output logic            wr_o,    // write strobe
	output logic      [7:0] wdata_o, // write data
	output logic            rd_o,    // read strobe
	input  wire logic [7:0] rdata_i  // read data
);
	initial begin
		addr_o = 8'h00;
		wr_o = 1'b0;
		wdata_o = 8'h00;
		rd_o = 1'b0;
	end
	// ----------------------------------------------------------------
	// bus cycles
	// ----------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		// stale data must not look like a valid write
		wdata_o <= ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		#1;
		d = rdata_i;
	endtask : rd
endmodule : ibc_host_model

// *** tb/ibc_regs_tb.sv ***
// self-checking testbench of the ibc register bank
`timescale 1ns/10ps
module ibc_regs_tb;
	import ibc_pkg::*;
	localparam int RC = 4;
	logic        clk, arst_n, ce, lp, vld, crst, cen, wr, rd;
	logic [11:0] r2, r3;
	logic [7:0]  addr, wdata, rdata, d;
	logic [3:0]  sch;
	ibc_rate_e   rate;
	int          error_cnt = 0;
	int          n_checks = 0;
	int          n;
	ibc_regs #(.READY_CYC(RC)) dut (.clk_i(clk), .arst_n_i(arst_n),
		.ce_i(ce), .addr_i(addr), .wr_i(wr), .wdata_i(wdata), .rd_i(rd),
		.rdata_o(rdata), .lowpower_i(lp), .res_vld_i(vld), .res_ch2_i(r2),
		.res_ch3_i(r3), .conv_en_o(cen), .core_rst_o(crst),
		.scan_ch_o(sch), .rate_o(rate));
	ibc_host_model h (.clk_i(clk), .addr_o(addr), .wr_o(wr),
		.wdata_o(wdata), .rd_o(rd), .rdata_i(rdata));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test
	task automatic chk(input string nm, input logic [7:0] e, g);
		n_checks++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			error_cnt++;
		end
	endtask : chk
	task automatic rchk(input logic [7:0] a, e);
		h.rd(a, d);
		chk($sformatf("reg %h", a), e, d);
	endtask : rchk
	// bounded: a bank that never gets ready ends the run
	task automatic wait_rdy(output int k);
		k = 0;
		while (cen !== 1'b1) begin
			@(posedge clk);
			#1;
			k++;
			if (k > 50) begin
				error_cnt++;
				end_of_test();
			end
		end
	endtask : wait_rdy
	task automatic push(input logic [11:0] a, b);
		@(posedge clk);
		vld <= 1'b1;
		r2 <= a;
		r3 <= b;
		@(posedge clk);
		vld <= 1'b0;
		r2 <= ~a;
		r3 <= ~b;
	endtask : push
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_defaults;
		rchk(IBC_OFS_STATUS, 8'h00);
		wait_rdy(n);
		rchk(IBC_OFS_STATUS, 8'h40);
		rchk(IBC_OFS_RESTART, 8'h00);
		rchk(IBC_OFS_ACTMASK, 8'h1F);
		rchk(IBC_OFS_NPSCAN, 8'h01);
		rchk(IBC_OFS_CH2_HI, 8'h00);
		rchk(IBC_OFS_CH3_LO, 8'h00);
		rchk(IBC_OFS_CH3_HI, 8'h00);
		rchk(8'h0B, 8'h00);
		$display("test defaults done");
	endtask : t_defaults
	// clock enable low must swallow writes, the hold clear included
	task automatic t_freeze;
		h.wr(IBC_OFS_RESTART, 8'h01);
		@(posedge clk);
		ce <= 1'b0;
		h.wr(IBC_OFS_ACTMASK, 8'h00);
		h.wr(IBC_OFS_RESTART, 8'h00);
		@(posedge clk);
		ce <= 1'b1;
		#1 chk("conv_en frozen", 8'h00, {7'h00, cen});
		rchk(IBC_OFS_ACTMASK, 8'h1F);
		h.wr(IBC_OFS_RESTART, 8'h00);
		$display("test clock enable done");
	endtask : t_freeze
	task automatic t_data_hold;
		push(12'hA5C, 12'h93E);
		h.wr(IBC_OFS_CH3_LO, 8'h77);
		rchk(IBC_OFS_CH2_HI, 8'h0A);
		rchk(IBC_OFS_CH3_LO, 8'h3E);
		rchk(IBC_OFS_CH3_HI, 8'h09);
		h.wr(IBC_OFS_RESTART, 8'h01);
		#1 chk("conv_en hold", 8'h00, {7'h00, cen});
		push(12'h123, 12'h456);
		rchk(IBC_OFS_CH3_LO, 8'h3E);
		rchk(IBC_OFS_NPSCAN, 8'h01);
		h.wr(IBC_OFS_RESTART, 8'h00);
		#1 chk("conv_en run", 8'h01, {7'h00, cen});
		$display("test data and hold done");
	endtask : t_data_hold
	task automatic t_rate;
		logic [7:0] v[10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h08, 8'h0B,
			8'h04, 8'h0E, 8'h04, 8'h0C};
		ibc_rate_e e[10] = '{IBC_RATE_80, IBC_RATE_40, IBC_RATE_20,
			IBC_RATE_10, IBC_RATE_160, IBC_RATE_160, IBC_RATE_CONT,
			IBC_RATE_CONT, IBC_RATE_80, IBC_RATE_160};
		h.wr(IBC_OFS_RESTART, 8'h01);
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			lp <= (i > 7);
			h.wr(IBC_OFS_NPSCAN, v[i]);
			#1 chk("rate", 8'(e[i]), 8'(rate));
		end
		@(posedge clk);
		lp <= 1'b0;
		h.wr(IBC_OFS_RESTART, 8'h00);
		$display("test rate done");
	endtask : t_rate
	task automatic t_scan;
		h.wr(IBC_OFS_RESTART, 8'h01);
		h.wr(IBC_OFS_ACTMASK, 8'h37);
		#1 chk("scan normal", 8'h07, {4'h0, sch});
		@(posedge clk);
		lp <= 1'b1;
		#1 chk("scan low power", 8'h03, {4'h0, sch});
		@(posedge clk);
		lp <= 1'b0;
		h.wr(IBC_OFS_RESTART, 8'h00);
		$display("test scan done");
	endtask : t_scan
	task automatic t_full;
		h.wr(IBC_OFS_RESTART, 8'h01);
		h.wr(IBC_OFS_NPSCAN, 8'h0B);
		h.wr(IBC_OFS_RESTART, 8'h00);
		fork
			h.wr(IBC_OFS_RESTART, 8'h10);
			begin
				@(posedge clk);
				#1 chk("restart pulse", 8'h01, {7'h00, crst});
			end
		join
		#1 chk("conv_en restart", 8'h00, {7'h00, cen});
		push(12'h7FF, 12'h8A5);
		wait_rdy(n);
		chk("ready delay", 8'(RC - 2), 8'(n));
		rchk(IBC_OFS_STATUS, 8'h40);
		rchk(IBC_OFS_RESTART, 8'h00);
		rchk(IBC_OFS_ACTMASK, 8'h1F);
		rchk(IBC_OFS_NPSCAN, 8'h01);
		rchk(IBC_OFS_CH2_HI, 8'h00);
		rchk(IBC_OFS_CH3_LO, 8'h00);
		$display("test full reset done");
	endtask : t_full
	initial begin
		arst_n = 1'b0;
		ce = 1'b1;
		lp = 1'b0;
		vld = 1'b0;
		r2 = 12'h000;
		r3 = 12'h000;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_defaults();
		t_freeze();
		t_data_hold();
		t_rate();
		t_scan();
		t_full();
		end_of_test();
	end
endmodule : ibc_regs_tb

// *** verilog/ibc_pkg.sv ***
// package: register map, field positions, reset values and timing for ibc
package ibc_pkg;
	localparam int          IBC_AW            = 8;
	localparam int          IBC_DW            = 8;
	// register offsets
	localparam logic [7:0]  IBC_OFS_STATUS    = 8'h00;
	localparam logic [7:0]  IBC_OFS_CH2_HI    = 8'h07;
	localparam logic [7:0]  IBC_OFS_CH3_LO    = 8'h08;
	localparam logic [7:0]  IBC_OFS_CH3_HI    = 8'h09;
	localparam logic [7:0]  IBC_OFS_RESTART   = 8'h0A;
	localparam logic [7:0]  IBC_OFS_ACTMASK   = 8'h0C;
	localparam logic [7:0]  IBC_OFS_NPSCAN    = 8'h0D;
	// reset values
	localparam logic [7:0]  IBC_RST_RESTART   = 8'h00;
	localparam logic [7:0]  IBC_RST_ACTMASK   = 8'h1F;
	localparam logic [7:0]  IBC_RST_NPSCAN    = 8'h01;
	// field positions
	localparam int          IBC_BIT_FULLRST   = 4;
	localparam int          IBC_BIT_HOLD      = 0;
	localparam int          IBC_BIT_READY     = 6;
	localparam int          IBC_BIT_FAST      = 3;
	localparam int          IBC_BIT_CONT      = 2;
	localparam int          IBC_LP_LSB        = 4;
	// scan rates in samples per second, core clock in hertz
	localparam int          IBC_SPS_FAST      = 160;
	localparam int          IBC_SPS_R0        = 80;
	localparam int          IBC_SPS_R1        = 40;
	localparam int          IBC_SPS_R2        = 20;
	localparam int          IBC_SPS_R3        = 10;
	localparam int          IBC_CLK_HZ        = 10_000_000;
	// time the core stays not ready after a full reset, in microseconds
	localparam int          IBC_READY_US      = 10;
	localparam int          IBC_READY_CYC     =
		(IBC_READY_US * (IBC_CLK_HZ / 1_000_000) < 1) ? 1 :
		IBC_READY_US * (IBC_CLK_HZ / 1_000_000);
	localparam int          IBC_CONT_CYC      = 1;

	typedef enum logic [2:0] {
		IBC_RATE_CONT = 3'b000,
		IBC_RATE_160  = 3'b001,
		IBC_RATE_80   = 3'b010,
		IBC_RATE_40   = 3'b011,
		IBC_RATE_20   = 3'b100,
		IBC_RATE_10   = 3'b101
	} ibc_rate_e;
endpackage : ibc_pkg

// *** verilog/ibc_regs.sv ***
// register bank of the inductive button controller: data, restart, enables
`timescale 1ns/10ps

// Behaviour
// - channel 2 result bits 11..8 read at 07h bits 3..0, 7..4 zero.
// - channel 3 result bits 7..0 read-only at 08h, zero after reset.
// - channel 3 result bits 11..8 read at 09h bits 3..0, 7..4 zero.
// - a one written to bit 4 at 0Ah restores every register default.
// - after a full reset no conversion runs until ready is one again.
// - status bit 6 reads zero while not ready after reset, then one.
// - while hold bit 0 at 0Ah is one no conversion runs, setup stays.
// - bits 3..0 at 0Ch enable channels 0..3, the register resets to 1Fh.
// - low-power scanning uses only channels whose bits 7..4 are one.
// - rate field 0/1/2/3 selects 80/40/20/10 samples per second.
// - fast bit 3 selects 160 per second over the field, not continuous.
// - continuous bit 2 in normal power scans back to back over all.
// - the continuous bit is ignored in low-power mode.
module ibc_regs
	import ibc_pkg::*;
#(
	parameter int READY_CYC = ibc_pkg::IBC_READY_CYC // not-ready time
) (
	input  wire logic                       clk_i,      // 10 MHz core clock
	input  wire logic                       arst_n_i,   // async reset, low
	input  wire logic                       ce_i,       // clock enable
	input  wire logic [ibc_pkg::IBC_AW-1:0] addr_i,     // register offset
	input  wire logic                       wr_i,       // write strobe
	input  wire logic [ibc_pkg::IBC_DW-1:0] wdata_i,    // write data
	input  wire logic                       rd_i,       // read strobe
	output logic      [ibc_pkg::IBC_DW-1:0] rdata_o,    // read data
	input  wire logic                       lowpower_i, // core in low power
	input  wire logic                       res_vld_i,  // new results pulse
	input  wire logic [11:0]                res_ch2_i,  // channel 2 result
	input  wire logic [11:0]                res_ch3_i,  // channel 3 result
	output logic                            conv_en_o,  // conversion allowed
	output logic                            core_rst_o, // core restart pulse
	output logic      [3:0]                 scan_ch_o,  // channels to scan
	output ibc_pkg::ibc_rate_e              rate_o      // selected scan rate
);
	import ibc_pkg::*;

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic rst_s1_r, rst_n_r;
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_s1_r <= 1'b0;
			rst_n_r  <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r  <= rst_s1_r;
		end
	end

	// ----------------------------------------------------------------
	// control registers and full restart
	// ----------------------------------------------------------------
	logic [7:0]  restart_r, actmask_r, npscan_r;
	logic [11:0] ch2_r, ch3_r;
	logic        ready_r;
	logic [$clog2(READY_CYC+1)-1:0] rdy_cnt_r;
	logic        full_rst;
	logic [7:0]  status_word;

	assign full_rst = ce_i && wr_i && addr_i == IBC_OFS_RESTART
		&& wdata_i[IBC_BIT_FULLRST];

	// a full restart reloads defaults in one cycle, so the bit never
	// reads back as one
	always_ff @(posedge clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			restart_r <= IBC_RST_RESTART;
			actmask_r <= IBC_RST_ACTMASK;
			npscan_r  <= IBC_RST_NPSCAN;
		end else if (full_rst) begin
			restart_r <= IBC_RST_RESTART;
			actmask_r <= IBC_RST_ACTMASK;
			npscan_r  <= IBC_RST_NPSCAN;
		end else if (ce_i && wr_i) begin
			unique case (addr_i)
				IBC_OFS_RESTART: restart_r <= wdata_i;
				IBC_OFS_ACTMASK: actmask_r <= wdata_i;
				IBC_OFS_NPSCAN:  npscan_r  <= wdata_i;
				default: ;
			endcase
		end
	end

	// ready drops on any reset and returns after READY_CYC cycles
	always_ff @(posedge clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ready_r   <= 1'b0;
			rdy_cnt_r <= '0;
		end else if (full_rst) begin
			ready_r   <= 1'b0;
			rdy_cnt_r <= '0;
		end else if (ce_i && !ready_r) begin
			if (rdy_cnt_r == ($bits(rdy_cnt_r))'(READY_CYC - 1))
				ready_r <= 1'b1;
			else
				rdy_cnt_r <= rdy_cnt_r + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// results
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ch2_r <= '0;
			ch3_r <= '0;
		end else if (full_rst) begin
			ch2_r <= '0;
			ch3_r <= '0;
		end else if (ce_i && res_vld_i && conv_en_o) begin
			ch2_r <= res_ch2_i;
			ch3_r <= res_ch3_i;
		end
	end

	// ----------------------------------------------------------------
	// read mux; unmapped offsets read zero
	// ----------------------------------------------------------------
	// ready is the only status flag this bank owns
	assign status_word = 8'(ready_r) << IBC_BIT_READY;

	always_ff @(posedge clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			rdata_o <= '0;
		end else if (ce_i && rd_i) begin
			unique case (addr_i)
				IBC_OFS_STATUS:  rdata_o <= status_word;
				IBC_OFS_CH2_HI:  rdata_o <= {4'h0, ch2_r[11:8]};
				IBC_OFS_CH3_LO:  rdata_o <= ch3_r[7:0];
				IBC_OFS_CH3_HI:  rdata_o <= {4'h0, ch3_r[11:8]};
				IBC_OFS_RESTART: rdata_o <= restart_r;
				IBC_OFS_ACTMASK: rdata_o <= actmask_r;
				IBC_OFS_NPSCAN:  rdata_o <= npscan_r;
				default:         rdata_o <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// steering outputs
	// ----------------------------------------------------------------
	assign conv_en_o  = ready_r && !restart_r[IBC_BIT_HOLD];
	assign core_rst_o = full_rst;
	// low-power enable is trusted to imply the normal enable
	assign scan_ch_o  = lowpower_i ? actmask_r[IBC_LP_LSB +: 4]
	                               : actmask_r[3:0];

	always_comb begin
		if (!lowpower_i && npscan_r[IBC_BIT_CONT])
			rate_o = IBC_RATE_CONT;
		else if (npscan_r[IBC_BIT_FAST])
			rate_o = IBC_RATE_160;
		else begin
			unique case (npscan_r[1:0])
				2'b00: rate_o = IBC_RATE_80;
				2'b01: rate_o = IBC_RATE_40;
				2'b10: rate_o = IBC_RATE_20;
				2'b11: rate_o = IBC_RATE_10;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_r);

	a_hi_nibble_zero: assert property (
		rd_i && ce_i && addr_i == IBC_OFS_CH2_HI
		|=> rdata_o == {4'h0, $past(ch2_r[11:8])})
		else $error("channel 2 high data mismatch");
	a_ch3_low_data: assert property (
		rd_i && ce_i && addr_i == IBC_OFS_CH3_LO
		|=> rdata_o == $past(ch3_r[7:0]))
		else $error("channel 3 low data mismatch");
	a_ch3_high_data: assert property (
		rd_i && ce_i && addr_i == IBC_OFS_CH3_HI
		|=> rdata_o == {4'h0, $past(ch3_r[11:8])})
		else $error("channel 3 high data mismatch");
	a_full_reset_defaults: assert property (
		full_rst |=> actmask_r == IBC_RST_ACTMASK
		&& npscan_r == IBC_RST_NPSCAN)
		else $error("full reset left non-default setup");
	a_no_conv_unready: assert property (
		!ready_r |-> !conv_en_o)
		else $error("conversion while not ready");
	a_ready_drops: assert property (
		full_rst |=> !ready_r [*2])
		else $error("ready did not drop after full reset");
	a_hold_blocks: assert property (
		restart_r[IBC_BIT_HOLD] |-> !conv_en_o)
		else $error("conversion during hold");
	a_lp_scan_set: assert property (
		lowpower_i |-> scan_ch_o == actmask_r[7:4])
		else $error("low-power scan set wrong");
	a_rate_field: assert property (
		!npscan_r[IBC_BIT_CONT] && !npscan_r[IBC_BIT_FAST]
		&& npscan_r[1:0] == 2'b01 |-> rate_o == IBC_RATE_40)
		else $error("rate field decode wrong");
	a_fast_override: assert property (
		npscan_r[IBC_BIT_FAST] && !npscan_r[IBC_BIT_CONT]
		|-> rate_o == IBC_RATE_160)
		else $error("fast rate not selected");
	a_cont_normal: assert property (
		npscan_r[IBC_BIT_CONT] && !lowpower_i |-> rate_o == IBC_RATE_CONT)
		else $error("continuous scan not selected");
	a_cont_lp_ignored: assert property (
		lowpower_i |-> rate_o != IBC_RATE_CONT)
		else $error("continuous scan in low power");
	a_fullrst_self_clear: assert property (
		full_rst |=> !restart_r[IBC_BIT_FULLRST])
		else $error("full reset bit stuck");

	c_full_reset:  cover property (full_rst ##1 !ready_r ##[1:200] ready_r);
	c_hold_entry:  cover property (ready_r && restart_r[IBC_BIT_HOLD]);
	c_cont_scan:   cover property (rate_o == IBC_RATE_CONT);
	c_result_load: cover property (res_vld_i && conv_en_o && ce_i);
endmodule : ibc_regs
